//--- dt_edge_detect.sv
// rising-edge detector for the external event pin
`timescale 1ns/100ps
module dt_edge_detect (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // sync reset, active low
   input wire logic i_level, // sampled level
   output logic o_rise // one-cycle pulse on rise
);
   typedef struct packed {
      logic prev;
   } dt_ed_state_t;
   dt_ed_state_t s_q, s_d;
   always_comb begin
      s_d.prev = i_level;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign o_rise = i_level & ~s_q.prev;
endmodule

//--- dt_pkg.sv
// package of register map, field positions and reset values for the down timer
package dt_pkg;
   localparam logic [2:0] DT_ADDR_CLK = 3'h0;
   localparam logic [2:0] DT_ADDR_MOD = 3'h1;
   localparam logic [2:0] DT_ADDR_CTL = 3'h2;
   localparam logic [2:0] DT_ADDR_TR = 3'h3;
   localparam logic [2:0] DT_ADDR_TC = 3'h4;
   localparam logic [2:0] DT_ADDR_INTF = 3'h5;
   localparam logic [2:0] DT_ADDR_INTE = 3'h6;
   localparam int DT_DEBUG_RUN_BIT_POS = 8;
   localparam int DT_DIV_POS = 4;
   localparam int DT_RUN_POS = 8;
   localparam int DT_PRESET_POS = 1;
   localparam int DT_EN_POS = 0;
   localparam logic [15:0] DT_TR_RESET = 16'hffff;
   localparam logic [15:0] DT_TC_RESET = 16'hffff;
   localparam logic [3:0] DT_DIV_MAX_FULL = 4'hf;
   localparam logic [3:0] DT_DIV_MAX_PART = 4'h8;
   localparam logic [1:0] DT_SRC_EXT = 2'h3;
   typedef enum logic [1:0] {
      DT_SRC_INTOSC = 2'b00,
      DT_SRC_LOWOSC = 2'b01,
      DT_SRC_HIGHOSC = 2'b10,
      DT_SRC_EXTERN = 2'b11
   } dt_src_t;
endpackage

//--- dt_prescaler.sv
// power-of-two prescaler turning source ticks into counter ticks
`timescale 1ns/100ps
module dt_prescaler (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // sync reset, active low
   input wire logic i_clr, // restart division
   input wire logic i_tick, // source tick
   input wire logic [3:0] i_div, // log2 of division ratio
   output logic o_tick // divided tick
);
   typedef struct packed {
      logic [14:0] cnt;
      logic tick;
   } dt_ps_state_t;
   dt_ps_state_t s_q, s_d;
   logic [14:0] mask;
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      mask = 15'((16'h0001 << i_div) - 16'h0001);
      if (i_clr) begin
         s_d.cnt = 15'h0000;
      end else if (i_tick) begin
         if ((s_q.cnt & mask) == mask) begin
            s_d.cnt = 15'h0000;
            s_d.tick = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 15'h0001;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign o_tick = s_q.tick;
endmodule

//--- dt_timer.sv
// one channel of the presettable 16-bit down timer with its register port
`timescale 1ns/100ps
module dt_timer #(
   parameter bit HAS_EVENT = 1'b1, // channel supports event counting
   parameter logic [3:0] SRC_AVAIL = 4'hf // per-source implemented mask
) (
   input wire logic i_clk, // 50 MHz system clock
   input wire logic i_rst_n, // sync reset, active low
   input wire logic [2:0] i_addr, // register index
   input wire logic [15:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [15:0] o_rdata, // read data, cycle after strobe
   input wire logic i_debug, // processor in debug mode
   input wire logic i_tick_intosc, // internal oscillator tick
   input wire logic i_tick_lowosc, // low-speed oscillator tick
   input wire logic i_tick_highosc, // high-speed oscillator tick
   input wire logic i_tick_extclk, // external clock input tick
   input wire logic i_event_pin, // external event pin level
   output logic o_underflow, // one-cycle underflow pulse
   output logic o_irq, // interrupt request level
   output logic o_running // run bit state
);
   typedef struct packed {
      logic debug_run_bit;
      logic [3:0] div;
      logic [1:0] src;
      logic oneshot;
      logic run;
      logic preset;
      logic en;
      logic [15:0] reload;
      logic [15:0] count;
      logic flag;
      logic ie;
      logic uf;
      logic irq;
      logic [15:0] rdata;
   } dt_state_t;

   dt_state_t s_q, s_d;
   logic ev_rise;
   logic div_tick;
   logic src_tick;
   logic clk_on;
   logic [3:0] div_eff;
   logic wr_clk, wr_mod, wr_ctl, wr_tr, wr_intf, wr_inte;
   logic [15:0] rd_mux;

   dt_edge_detect u_edge (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_level(i_event_pin),
      .o_rise(ev_rise)
   );

   // operating clock exists only while enabled and not frozen by debug
   assign clk_on = s_q.en & (~i_debug | s_q.debug_run_bit);

   always_comb begin
      case (s_q.src)
         dt_pkg::DT_SRC_INTOSC: src_tick = i_tick_intosc;
         dt_pkg::DT_SRC_LOWOSC: src_tick = i_tick_lowosc;
         dt_pkg::DT_SRC_HIGHOSC: src_tick = i_tick_highosc;
         dt_pkg::DT_SRC_EXTERN: src_tick = HAS_EVENT ? ev_rise : i_tick_extclk;
         default: src_tick = 1'b0;
      endcase
      // high-speed source only reaches 1/256; external is undivided
      if (s_q.src == dt_pkg::DT_SRC_EXT) begin
         div_eff = 4'h0;
      end else if (s_q.src == dt_pkg::DT_SRC_HIGHOSC && s_q.div > dt_pkg::DT_DIV_MAX_PART) begin
         div_eff = dt_pkg::DT_DIV_MAX_PART;
      end else begin
         div_eff = s_q.div;
      end
   end

   dt_prescaler u_ps (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_clr(~s_q.run),
      .i_tick(src_tick & clk_on),
      .i_div(div_eff),
      .o_tick(div_tick)
   );

   always_comb begin
      wr_clk = i_wr && i_addr == dt_pkg::DT_ADDR_CLK;
      wr_mod = i_wr && i_addr == dt_pkg::DT_ADDR_MOD;
      wr_ctl = i_wr && i_addr == dt_pkg::DT_ADDR_CTL;
      wr_tr = i_wr && i_addr == dt_pkg::DT_ADDR_TR;
      wr_intf = i_wr && i_addr == dt_pkg::DT_ADDR_INTF;
      wr_inte = i_wr && i_addr == dt_pkg::DT_ADDR_INTE;
      // reserved bits and unmapped indices read zero
      case (i_addr)
         dt_pkg::DT_ADDR_CLK: rd_mux = {7'h00, s_q.debug_run_bit, s_q.div, 2'h0, s_q.src};
         dt_pkg::DT_ADDR_MOD: rd_mux = {15'h0000, s_q.oneshot};
         dt_pkg::DT_ADDR_CTL: rd_mux = {7'h00, s_q.run, 6'h00, s_q.preset, s_q.en};
         dt_pkg::DT_ADDR_TR: rd_mux = s_q.reload;
         dt_pkg::DT_ADDR_TC: rd_mux = s_q.count;
         dt_pkg::DT_ADDR_INTF: rd_mux = {15'h0000, s_q.flag};
         dt_pkg::DT_ADDR_INTE: rd_mux = {15'h0000, s_q.ie};
         default: rd_mux = 16'h0000;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.uf = 1'b0;
      s_d.rdata = i_rd ? rd_mux : 16'h0000;
      if (wr_clk) begin
         s_d.debug_run_bit = i_wdata[dt_pkg::DT_DEBUG_RUN_BIT_POS];
         s_d.div = i_wdata[dt_pkg::DT_DIV_POS +: 4];
         // an absent source is refused and the old one stays
         if (SRC_AVAIL[i_wdata[1:0]]) begin
            s_d.src = i_wdata[1:0];
         end
      end
      if (wr_mod) begin
         s_d.oneshot = i_wdata[0];
      end
      if (wr_tr) begin
         s_d.reload = i_wdata;
      end
      if (wr_inte) begin
         s_d.ie = i_wdata[0];
      end
      if (wr_ctl) begin
         s_d.en = i_wdata[dt_pkg::DT_EN_POS];
         // run and preset need enable set in this same write
         if (i_wdata[dt_pkg::DT_EN_POS]) begin
            s_d.run = i_wdata[dt_pkg::DT_RUN_POS];
            if (i_wdata[dt_pkg::DT_PRESET_POS]) begin
               s_d.preset = 1'b1;
            end
         end else begin
            s_d.run = 1'b0;
         end
      end
      if (wr_intf && i_wdata[0]) begin
         s_d.flag = 1'b0;
      end
      // preset takes one cycle, then the busy bit self-clears
      if (s_q.preset) begin
         s_d.count = s_q.reload;
         s_d.preset = 1'b0;
      end else if (s_q.run && div_tick && clk_on) begin
         if (s_q.count == 16'h0000) begin
            s_d.count = s_q.reload;
            s_d.uf = 1'b1;
            s_d.flag = 1'b1;
            if (s_q.oneshot) begin
               s_d.run = 1'b0;
            end
         end else begin
            s_d.count = s_q.count - 16'h0001;
         end
      end
      s_d.irq = s_d.flag & s_d.ie;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_q <= '0;
         s_q.reload <= dt_pkg::DT_TR_RESET;
         s_q.count <= dt_pkg::DT_TC_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_underflow = s_q.uf;
   assign o_irq = s_q.irq;
   assign o_running = s_q.run;
endmodule

//--- dt_timer_properties.sv
// port-level assertions for the down timer channel
`timescale 1ns/100ps
module dt_timer_props (
   input wire logic i_clk, // clock
   input wire logic i_rst_n, // reset
   input wire logic [2:0] i_addr, // index
   input wire logic [15:0] i_wdata, // data
   input wire logic i_wr, // write
   input wire logic i_rd, // read
   input wire logic [15:0] o_rdata, // read data
   input wire logic o_underflow, // pulse
   input wire logic o_irq, // request
   input wire logic o_running // run state
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic go;
   logic halt;
   // enable rides in the same register, so a start write must carry it
   assign go = i_wr && i_addr == dt_pkg::DT_ADDR_CTL && i_wdata[8] && i_wdata[0];
   assign halt = i_wr && i_addr == dt_pkg::DT_ADDR_CTL && !go;
   run_start_a: assert property ($rose(o_running) |-> $past(go) || $past(go, 2))
      else $error("run rose without enabled start");
   run_stop_a: assert property ($fell(o_running) |-> o_underflow || $past(o_underflow)
      || $past(halt) || $past(halt, 2)) else $error("run fell without cause");
   uf_run_a: assert property (o_underflow |-> $past(o_running))
      else $error("underflow while stopped");
   irq_rise_a: assert property ($rose(o_irq) |-> o_underflow || $past(o_underflow)
      || $past(i_wr) || $past(i_wr, 2)) else $error("request without cause");
   irq_fall_a: assert property ($fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2))
      else $error("request dropped without write");
   unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) == 3'h7
      |-> o_rdata == 16'h0) else $error("unmapped read not zero");
   rsvd_low_a: assert property ($past(i_rd) && $past(i_addr) inside {3'h1, 3'h5, 3'h6}
      |-> o_rdata[15:1] == 15'h0) else $error("reserved bits set");
   rsvd_clk_a: assert property ($past(i_rd) && $past(i_addr) == 3'h0
      |-> o_rdata[15:9] == 7'h0 && o_rdata[3:2] == 2'h0) else $error("clock reserved set");
   cover property (o_underflow);
   cover property ($rose(o_irq));
   cover property ($fell(o_running));
endmodule
bind dt_timer dt_timer_props i_props (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .o_underflow, .o_irq, .o_running);

//--- dt_timer_tb.sv
// self-checking bench for the down timer channel
`timescale 1ns/100ps
`define CK(s, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h got %h", s, e, g); end end
module dt_timer_tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [15:0] i_wdata = 16'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_debug = 1'b0;
   logic i_tick_intosc = 1'b1;
   logic i_tick_highosc = 1'b1;
   logic i_event_pin = 1'b0;
   logic [15:0] o_rdata;
   logic o_underflow;
   logic o_irq;
   logic o_running;
   int bad_count = 0;
   int checked = 0;
   int n;
   // low-speed source left absent so that a refused source select can be seen
   dt_timer #(.SRC_AVAIL(4'hd)) i_dut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_debug, .i_tick_intosc, .i_tick_lowosc(1'b0), .i_tick_highosc, .i_tick_extclk(1'b0),
      .i_event_pin, .o_underflow, .o_irq, .o_running);
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] e, input string s);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      `CK(s, e, o_rdata)
   endtask
   // counts cycles up to the next underflow pulse, giving up at lim
   task automatic uf(input int lim);
      n = 0;
      do begin
         @(posedge i_clk);
         // look just after the edge, once the registered pulse has settled
         #1;
         n++;
      end while (o_underflow !== 1'b1 && n < lim);
   endtask
   task automatic t_regs();
      logic [15:0] ex [8];
      ex = '{16'h0, 16'h0, 16'h0, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0};
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), ex[a], "reset value");
      end
      wr(3'h0, 16'hffff);
      rd(3'h0, 16'h01f3, "clock reg");
      wr(3'h1, 16'hffff);
      rd(3'h1, 16'h0001, "mode reg");
      wr(3'h4, 16'h0);
      rd(3'h4, 16'hffff, "count ro");
      wr(3'h2, 16'h0102);
      rd(3'h2, 16'h0, "run needs enable");
      wr(3'h0, 16'h0);
   endtask
   task automatic t_oneshot();
      wr(3'h3, 16'h0003);
      wr(3'h2, 16'h0103);
      uf(200);
      `CK("oneshot underflow", 1'b1, o_underflow)
      rd(3'h2, 16'h0001, "oneshot stop");
      rd(3'h4, 16'h0003, "reload");
      rd(3'h5, 16'h0001, "flag set");
      `CK("irq masked", 1'b0, o_irq)
      wr(3'h5, 16'h0);
      rd(3'h5, 16'h0001, "flag kept");
      wr(3'h5, 16'h0001);
      rd(3'h5, 16'h0, "flag clear");
      wr(3'h6, 16'hffff);
      rd(3'h6, 16'h0001, "irq enable");
      `CK("irq idle", 1'b0, o_irq)
      wr(3'h2, 16'h0103);
      uf(200);
      `CK("irq up", 1'b1, o_irq)
      wr(3'h5, 16'h0001);
      rd(3'h5, 16'h0, "flag reclear");
      `CK("irq down", 1'b0, o_irq)
   endtask
   task automatic t_repeat();
      wr(3'h1, 16'h0);
      wr(3'h3, 16'h0004);
      wr(3'h2, 16'h0103);
      uf(200);
      uf(200);
      `CK("period", 5, n)
      wr(3'h2, 16'h0001);
      wr(3'h0, 16'h0020);
      wr(3'h2, 16'h0101);
      uf(200);
      uf(200);
      `CK("div period", 20, n)
      @(posedge i_clk);
      i_debug <= 1'b1;
      uf(100);
      `CK("debug hold", 100, n)
      wr(3'h0, 16'h0120);
      uf(100);
      uf(100);
      `CK("debug run", 20, n)
      @(posedge i_clk);
      i_debug <= 1'b0;
      wr(3'h2, 16'h0001);
      rd(3'h2, 16'h0001, "stopped");
   endtask
   // high-speed source asked for 1/32,768 must stop at 1/256; then a reset mid-run
   task automatic t_cap();
      wr(3'h3, 16'h0001);
      wr(3'h0, 16'h00f2);
      wr(3'h2, 16'h0103);
      uf(600);
      uf(600);
      `CK("capped period", 512, n)
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      `CK("reset run", 1'b0, o_running)
      `CK("reset irq", 1'b0, o_irq)
      rd(3'h3, 16'hffff, "reset reload");
      rd(3'h4, 16'hffff, "reset count");
   endtask
   // event pin counting, undivided even with a divider code set
   task automatic t_event();
      int ufs;
      ufs = 0;
      wr(3'h3, 16'h0002);
      wr(3'h0, 16'h0053);
      // write then read with no gap to catch the one-cycle preset busy bit
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= 3'h2;
      i_wdata <= 16'h0003;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      `CK("preset busy", 16'h0003, o_rdata)
      rd(3'h2, 16'h0001, "preset done");
      rd(3'h4, 16'h0002, "preset count");
      wr(3'h2, 16'h0101);
      for (int k = 0; k < 7; k++) begin
         @(posedge i_clk);
         i_event_pin <= 1'b1;
         @(posedge i_clk);
         i_event_pin <= 1'b0;
         @(posedge i_clk);
         #1;
         if (o_underflow === 1'b1) begin
            ufs++;
         end
      end
      `CK("event underflows", 2, ufs)
      rd(3'h4, 16'h0001, "event count");
      rd(3'h2, 16'h0101, "running");
      wr(3'h0, 16'h0001);
      rd(3'h0, 16'h0003, "absent source");
   endtask
   task automatic summarize();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_oneshot();
      t_repeat();
      t_cap();
      t_event();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      bad_count++;
      summarize();
   end
endmodule
